// ==== core/acct_top.sv ====
// Calibration trigger, status routing and low-power sequencing with APB
//
// Contract
// - Halt flag reads 1 once background stops at request, 0 when it resumes.
// - With background off, halt flag sets when foreground finishes or is skipped.
// - Foreground-complete status bit 0 goes high when foreground finishes.
// - Status pin: 0 foreground-complete, 1 reserved, 2 fault, 3 held low.
// - Trigger select 0 uses software bit and ignores the trigger pin.
// - Trigger select 1 uses the trigger pin and ignores the software bit.
// - Sleep code k gives (2^k+1)*256 clocks, k from 3,15,18,...,33.
// - Sleep code acts only with low power on and triggered sleep off.
// - Settle code gives (2^k+1)*256 clocks, k 3,18,21,24; low power only.
// - Triggered sleep off: sleep length comes from the sleep code.
// - Triggered sleep on: cores sleep until the selected trigger is low.
// - Low-power enable resets 0 and acts only with background enabled.
// - Background enable resets 0; 1 runs background calibration.
// - Foreground run bit resets 1; clears values, runs or skips foreground.
`include "acct_defs.svh"
module acct_top
#(
    parameter logic [8:0] LP_UNIT_CYCLES = 9'h100
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic trigger_input_pin_i,
    input wire logic fault_i,
    output logic status_output_pin_o,
    output logic [1:0] core_sleep_o,
    output logic [1:0] core_cal_o
);
    // ************************************
    // Registers and decode
    // ************************************
    logic [7:0] cfg_reg;
    logic [7:0] pin_reg;
    logic [7:0] soft_reg;
    logic [7:0] lp_reg;
    logic foreground_complete_reg;
    logic halted_reg;
    logic restart_reg;
    logic [7:0] rd_idx;
    logic addr_ok;
    logic acc;
    logic wr;
    logic [1:0] pin_sync;
    logic trig;
    logic lp_active;
    logic [15:0] cnt_reg;
    logic core_reg;
    logic tstart_reg;
    logic tsettle_reg;
    logic tabort_reg;
    acct_pkg::acct_state_t state_reg;
    acct_timer_if tmr ();

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == `ACCT_IDX_CFG || idx == `ACCT_IDX_STAT ||
               idx == `ACCT_IDX_PIN || idx == `ACCT_IDX_SOFT ||
               idx == `ACCT_IDX_LP;
    endfunction

    assign rd_idx = paddr_i[9:2];
    assign addr_ok = is_mapped(rd_idx) && paddr_i[11:10] == 2'h0 &&
                     paddr_i[1:0] == 2'h0;
    assign acc = psel_i && penable_i && pready_o;
    assign wr = acc && pwrite_i && addr_ok && pstrb_i[0];

    // ************************************
    // APB answer
    // ************************************
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end
        else
        begin
            pready_o <= psel_i && penable_i && !pready_o;
            if (psel_i && penable_i && !pready_o)
            begin
                pslverr_o <= !addr_ok;
                prdata_o <= 32'h0;
                if (!pwrite_i && addr_ok)
                    unique case (rd_idx)
                        `ACCT_IDX_CFG: prdata_o[7:0] <= cfg_reg;
                        `ACCT_IDX_STAT: prdata_o[7:0] <= {6'h00, halted_reg,
                                                          foreground_complete_reg};
                        `ACCT_IDX_PIN: prdata_o[7:0] <= pin_reg;
                        `ACCT_IDX_SOFT: prdata_o[7:0] <= soft_reg;
                        `ACCT_IDX_LP: prdata_o[7:0] <= lp_reg;
                        default: prdata_o[7:0] <= 8'h00;
                    endcase
            end
        end
    end

    // ************************************
    // Register writes
    // ************************************
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_reg <= `ACCT_RST_CFG;
            pin_reg <= `ACCT_RST_PIN;
            soft_reg <= `ACCT_RST_SOFT;
            lp_reg <= `ACCT_RST_LP;
        end
        else if (wr)
        begin
            if (rd_idx == `ACCT_IDX_CFG)
                cfg_reg <= pwdata_i[7:0];
            if (rd_idx == `ACCT_IDX_PIN)
                pin_reg <= pwdata_i[7:0];
            if (rd_idx == `ACCT_IDX_SOFT)
                soft_reg <= pwdata_i[7:0];
            if (rd_idx == `ACCT_IDX_LP)
                lp_reg <= pwdata_i[7:0];
        end
    end

    // Rewriting the configuration clears values and reruns the sequence
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            restart_reg <= 1'b1;
        else
            restart_reg <= wr && rd_idx == `ACCT_IDX_CFG;
    end

    // ************************************
    // Trigger and status pin
    // ************************************
    acct_sync3 u_sync
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i({fault_i, trigger_input_pin_i}),
        .sync_o(pin_sync)
    );

    assign trig = pin_reg[`ACCT_PIN_TRIG] ? pin_sync[0]
                                          : soft_reg[`ACCT_SOFT_BIT];
    assign lp_active = lp_reg[`ACCT_LOW_POWER_CAL_ENABLE] && cfg_reg[`ACCT_CFG_BG];

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            status_output_pin_o <= 1'b0;
        else
            unique case (pin_reg[`ACCT_PIN_SEL])
                `ACCT_SEL_FG: status_output_pin_o <= foreground_complete_reg;
                `ACCT_SEL_FAULT: status_output_pin_o <= pin_sync[1];
                default: status_output_pin_o <= 1'b0;
            endcase
    end

    // ************************************
    // Calibration sequencer
    // ************************************
    assign tmr.start = tstart_reg;
    assign tmr.settle = tsettle_reg;
    assign tmr.abort = tabort_reg;
    assign tmr.code = tsettle_reg ? {1'b0, lp_reg[`ACCT_LP_WAKE]}
                                  : lp_reg[`ACCT_LP_SLEEP];

    acct_lp_timer #(.UNIT_CYCLES(LP_UNIT_CYCLES)) u_timer
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tmr(tmr.timer)
    );

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= acct_pkg::S_FG;
            cnt_reg <= 16'h0;
            core_reg <= 1'b0;
            foreground_complete_reg <= 1'b0;
            tstart_reg <= 1'b0;
            tsettle_reg <= 1'b0;
            tabort_reg <= 1'b0;
        end
        else if (restart_reg)
        begin
            state_reg <= acct_pkg::S_FG;
            cnt_reg <= 16'h0;
            core_reg <= 1'b0;
            foreground_complete_reg <= 1'b0;
            tstart_reg <= 1'b0;
            tabort_reg <= 1'b1;
        end
        else
        begin
            tstart_reg <= 1'b0;
            tabort_reg <= 1'b0;
            unique case (state_reg)
                acct_pkg::S_FG:
                begin
                    cnt_reg <= cnt_reg + 16'h1;
                    if (!cfg_reg[`ACCT_CFG_FG] || cnt_reg == `ACCT_FG_LAST)
                    begin
                        foreground_complete_reg <= cfg_reg[`ACCT_CFG_FG];
                        cnt_reg <= 16'h0;
                        state_reg <= cfg_reg[`ACCT_CFG_BG] ? acct_pkg::S_BGCAL
                                                           : acct_pkg::S_IDLE;
                    end
                end
                acct_pkg::S_IDLE:
                    if (cfg_reg[`ACCT_CFG_BG])
                        state_reg <= acct_pkg::S_BGCAL;
                acct_pkg::S_BGCAL:
                begin
                    cnt_reg <= cnt_reg + 16'h1;
                    if (!cfg_reg[`ACCT_CFG_BG])
                        state_reg <= acct_pkg::S_IDLE;
                    else if (cnt_reg == `ACCT_BG_LAST)
                    begin
                        cnt_reg <= 16'h0;
                        core_reg <= !core_reg;
                        if (cfg_reg[`ACCT_CFG_HALT])
                            state_reg <= acct_pkg::S_HALT;
                        else if (lp_active)
                            state_reg <= acct_pkg::S_SLEEP;
                    end
                end
                acct_pkg::S_SLEEP:
                begin
                    tsettle_reg <= 1'b0;
                    if (!lp_active)
                    begin
                        tabort_reg <= 1'b1;
                        state_reg <= acct_pkg::S_BGCAL;
                    end
                    else if (lp_reg[`ACCT_TRIGGERED_SLEEP_MODE])
                    begin
                        tabort_reg <= 1'b1;
                        if (!trig)
                        begin
                            tstart_reg <= 1'b1;
                            tsettle_reg <= 1'b1;
                            state_reg <= acct_pkg::S_SETTLE;
                        end
                    end
                    else if (tmr.done)
                    begin
                        tstart_reg <= 1'b1;
                        tsettle_reg <= 1'b1;
                        state_reg <= acct_pkg::S_SETTLE;
                    end
                    else if (!tmr.busy && !tstart_reg)
                        tstart_reg <= 1'b1;
                end
                acct_pkg::S_SETTLE:
                    if (!lp_active || tmr.done)
                    begin
                        tabort_reg <= !tmr.done;
                        tsettle_reg <= 1'b0;
                        state_reg <= acct_pkg::S_BGCAL;
                    end
                acct_pkg::S_HALT:
                    if (!cfg_reg[`ACCT_CFG_BG])
                        state_reg <= acct_pkg::S_IDLE;
                    else if (!cfg_reg[`ACCT_CFG_HALT])
                        state_reg <= acct_pkg::S_BGCAL;
                default:
                    state_reg <= acct_pkg::S_FG;
            endcase
        end
    end

    // ************************************
    // Halt flag and core outputs
    // ************************************
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            halted_reg <= 1'b0;
        else
            halted_reg <= state_reg == acct_pkg::S_HALT ||
                          state_reg == acct_pkg::S_IDLE;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            core_sleep_o <= 2'h0;
            core_cal_o <= 2'h0;
        end
        else
        begin
            core_sleep_o <= 2'h0;
            core_cal_o <= 2'h0;
            if (state_reg == acct_pkg::S_SLEEP)
                core_sleep_o[core_reg] <= 1'b1;
            if (state_reg == acct_pkg::S_BGCAL)
                core_cal_o[core_reg] <= 1'b1;
        end
    end

    // ************************************
    // Checks
    // ************************************
    halt_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_HALT |=> halted_reg)
        else $error("halt flag not set while stopped");

    resume_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_BGCAL |=> !halted_reg)
        else $error("halt flag set while running");

    fg_skip_halt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_FG && !restart_reg && !cfg_reg[`ACCT_CFG_BG] &&
        !cfg_reg[`ACCT_CFG_FG] && !wr |=> ##1 halted_reg)
        else $error("halt flag missing after skipped foreground");

    foreground_complete_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_FG && !restart_reg && cfg_reg[`ACCT_CFG_FG] &&
        cnt_reg == `ACCT_FG_LAST |=> foreground_complete_reg ##1 (foreground_complete_reg || $past(restart_reg)))
        else $error("foreground complete not raised");

    pin_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pin_reg[`ACCT_PIN_SEL] == `ACCT_SEL_LOW |=> !status_output_pin_o)
        else $error("status pin not held low");

    sw_trig_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_SLEEP && !restart_reg && lp_active &&
        lp_reg[`ACCT_TRIGGERED_SLEEP_MODE] && !pin_reg[`ACCT_PIN_TRIG] &&
        soft_reg[`ACCT_SOFT_BIT] |=> state_reg == acct_pkg::S_SLEEP)
        else $error("woke while software trigger high");

    hw_trig_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_SLEEP && !restart_reg && lp_active &&
        lp_reg[`ACCT_TRIGGERED_SLEEP_MODE] && pin_reg[`ACCT_PIN_TRIG] &&
        pin_sync[0] |=> state_reg == acct_pkg::S_SLEEP)
        else $error("woke while trigger pin high");

    trig_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == acct_pkg::S_SLEEP && !restart_reg && lp_active &&
        lp_reg[`ACCT_TRIGGERED_SLEEP_MODE] && !trig |=> state_reg == acct_pkg::S_SETTLE)
        else $error("low trigger did not wake core");

    lp_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !lp_active |=> state_reg != acct_pkg::S_SLEEP)
        else $error("sleep without low power enabled");

    skip_fg_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        restart_reg && !cfg_reg[`ACCT_CFG_FG] && !wr |=>
        state_reg == acct_pkg::S_FG ##1 state_reg != acct_pkg::S_FG)
        else $error("foreground not skipped");
endmodule

// ==== core/acct_defs.svh ====
// Register indices, field positions, reset values and interval codes
`ifndef ACCT_DEFS_SVH
`define ACCT_DEFS_SVH

`define ACCT_IDX_CFG 8'h62
`define ACCT_IDX_STAT 8'h6a
`define ACCT_IDX_PIN 8'h6b
`define ACCT_IDX_SOFT 8'h6c
`define ACCT_IDX_LP 8'h6e

`define ACCT_RST_CFG 8'h01
`define ACCT_RST_PIN 8'h00
`define ACCT_RST_SOFT 8'h01
`define ACCT_RST_LP 8'h88

`define ACCT_CFG_FG 0
`define ACCT_CFG_BG 1
`define ACCT_CFG_HALT 2
`define ACCT_PIN_TRIG 0
`define ACCT_PIN_SEL 2:1
`define ACCT_SOFT_BIT 0
`define ACCT_LOW_POWER_CAL_ENABLE 0
`define ACCT_TRIGGERED_SLEEP_MODE 1
`define ACCT_LP_WAKE 4:3
`define ACCT_LP_SLEEP 7:5

`define ACCT_SEL_FG 2'h0
`define ACCT_SEL_FAULT 2'h2
`define ACCT_SEL_LOW 2'h3

`define ACCT_FG_LAST 16'h03ff
`define ACCT_BG_LAST 16'h03ff
`define ACCT_TW 42

`define ACCT_KS0 6'h03
`define ACCT_KS1 6'h0f
`define ACCT_KS2 6'h12
`define ACCT_KS3 6'h15
`define ACCT_KS4 6'h18
`define ACCT_KS5 6'h1b
`define ACCT_KS6 6'h1e
`define ACCT_KS7 6'h21

`endif

// ==== core/acct_pkg.sv ====
// Types shared by the calibration sequencer
package acct_pkg;
    typedef enum logic [2:0] {
        S_FG = 3'h0,
        S_BGCAL = 3'h1,
        S_SLEEP = 3'h3,
        S_SETTLE = 3'h2,
        S_HALT = 3'h6,
        S_IDLE = 3'h4
    } acct_state_t;
endpackage

// ==== core/acct_timer_if.sv ====
// Handshake between sequencer and low-power interval timer
interface acct_timer_if;
    logic start;
    logic settle;
    logic abort;
    logic [2:0] code;
    logic busy;
    logic done;
    modport ctrl (output start, output settle, output abort, output code,
                  input busy, input done);
    modport timer (input start, input settle, input abort, input code,
                   output busy, output done);
endinterface

// ==== core/acct_sync3.sv ====
// Three-stage input synchroniser with agreement filter
module acct_sync3
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] async_i,
    output logic [1:0] sync_o
);
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bit
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    s1_reg[g] <= 1'b0;
                    s2_reg[g] <= 1'b0;
                    s3_reg[g] <= 1'b0;
                    sync_o[g] <= 1'b0;
                end
                else
                begin
                    s1_reg[g] <= async_i[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g])
                        sync_o[g] <= s3_reg[g];
                end
            end
        end
    endgenerate
endmodule

// ==== core/acct_lp_timer.sv ====
// Sleep and settle interval timer
`include "acct_defs.svh"
module acct_lp_timer
#(
    parameter logic [8:0] UNIT_CYCLES = 9'h100
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    acct_timer_if.timer tmr
);
    logic [`ACCT_TW-1:0] cnt_reg;
    logic [`ACCT_TW-1:0] last_reg;

    function automatic logic [`ACCT_TW-1:0] last_of(input logic settle,
                                                    input logic [2:0] code);
        logic [5:0] k;
        logic [`ACCT_TW-1:0] t;
        k = `ACCT_KS0;
        if (settle)
            k = (code[1:0] == 2'h0) ? `ACCT_KS0 :
                (code[1:0] == 2'h1) ? `ACCT_KS2 :
                (code[1:0] == 2'h2) ? `ACCT_KS3 : `ACCT_KS4;
        else
            unique case (code)
                3'h0: k = `ACCT_KS0;
                3'h1: k = `ACCT_KS1;
                3'h2: k = `ACCT_KS2;
                3'h3: k = `ACCT_KS3;
                3'h4: k = `ACCT_KS4;
                3'h5: k = `ACCT_KS5;
                3'h6: k = `ACCT_KS6;
                3'h7: k = `ACCT_KS7;
            endcase
        t = (`ACCT_TW'(1) << k) + `ACCT_TW'(1);
        return `ACCT_TW'(t * `ACCT_TW'(UNIT_CYCLES)) - `ACCT_TW'(1);
    endfunction

    // Interval is (2^k+1) units of device clock
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= '0;
            last_reg <= '0;
            tmr.busy <= 1'b0;
            tmr.done <= 1'b0;
        end
        else
        begin
            tmr.done <= 1'b0;
            // Start beats abort so a triggered wake relaunches the settle wait
            if (tmr.start)
            begin
                cnt_reg <= '0;
                last_reg <= last_of(tmr.settle, tmr.code);
                tmr.busy <= 1'b1;
            end
            else if (tmr.abort)
                tmr.busy <= 1'b0;
            else if (tmr.busy)
            begin
                cnt_reg <= cnt_reg + `ACCT_TW'(1);
                if (cnt_reg == last_reg)
                begin
                    tmr.busy <= 1'b0;
                    tmr.done <= 1'b1;
                end
            end
        end
    end

    done_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tmr.start && !tmr.abort |=> !tmr.done [*8])
        else $error("interval timer finished too early");
endmodule

// ==== test/acct_host_model.sv ====
// Host-side pin driver for the calibration trigger and fault inputs
module acct_host_model
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic trig_low_i,
    input wire logic fault_on_i,
    output logic trigger_input_pin_o,
    output logic fault_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Trigger idles high when no trigger is wanted
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            trigger_input_pin_o <= 1'b1;
        else
            trigger_input_pin_o <= ~trig_low_i;
    end

    // Fault level
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fault_o <= 1'b0;
        else
            fault_o <= fault_on_i;
    end
endmodule

// ==== test/test_adc_calibration_trigger_ctrl.sv ====
// Register-level test of calibration trigger and low-power sequencing
`include "acct_defs.svh"
module test_adc_calibration_trigger_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic trig_low = 1'b0;
    logic fault_on = 1'b0;
    logic trig_pin;
    logic fault;
    logic stat_pin;
    logic [1:0] core_sleep;
    logic [1:0] core_cal;
    int error_cnt = 0;
    int tests_run = 0;

    always #2.5 clk_i = ~clk_i;

    acct_top #(.LP_UNIT_CYCLES(9'h001)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .trigger_input_pin_i(trig_pin), .fault_i(fault),
        .status_output_pin_o(stat_pin), .core_sleep_o(core_sleep), .core_cal_o(core_cal));

    acct_host_model host_u (.clk_i(clk_i), .nrst_i(nrst_i), .trig_low_i(trig_low),
        .fault_on_i(fault_on), .trigger_input_pin_o(trig_pin), .fault_o(fault));

    // ****************
    // Checking and ending
    // ****************
    task wrap_up;
        $display("Compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // ****************
    // Bus and wait tasks
    // ****************
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
             output logic [31:0] rdat, output logic err);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {2'h0, idx, 2'h0};
        pwdata_i <= {24'h000000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        rdat = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50)
        begin
            chk("bus answer", 32'h1, 32'h0);
            wrap_up();
        end
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, idx, d, v, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask

    task rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] v;
        logic e;
        apb(1'b0, idx, 8'h00, v, e);
        chk(nm, exp, v);
    endtask

    // Which: 0 any core asleep, 1 any core calibrating, 2 status pin
    task wsig(input int which, input logic want, input int lim, output int n);
        logic s;
        for (n = 0; n < lim; n++)
        begin
            @(posedge clk_i);
            s = (which == 0) ? |core_sleep : (which == 1) ? |core_cal : stat_pin;
            if (s === want)
                break;
        end
        if (n >= lim)
        begin
            chk("wait level", {31'h0, want}, {31'h0, s});
            wrap_up();
        end
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        int n;
        logic [31:0] v;
        logic e;
        logic [3:0] pexp;
        pexp = 4'b0101;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`ACCT_IDX_PIN, 32'h00, "pin routing reset");
        rd(`ACCT_IDX_SOFT, 32'h01, "soft trigger reset");
        rd(`ACCT_IDX_LP, 32'h88, "low power reset");
        rd(`ACCT_IDX_CFG, 32'h01, "config reset");
        apb(1'b0, 8'h10, 8'h00, v, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        wsig(2, 1'b1, 1200, n);
        rd(`ACCT_IDX_STAT, 32'h03, "status after foreground");
        fault_on <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            wr(`ACCT_IDX_PIN, 8'(s * 2));
            repeat (8) @(posedge clk_i);
            chk("status pin", {31'h0, pexp[s]}, {31'h0, stat_pin});
        end
        fault_on <= 1'b0;
        wr(`ACCT_IDX_PIN, 8'h04);
        repeat (8) @(posedge clk_i);
        chk("status pin fault off", 32'h0, {31'h0, stat_pin});
        wr(`ACCT_IDX_CFG, 8'h00);
        repeat (5) @(posedge clk_i);
        apb(1'b0, `ACCT_IDX_STAT, 8'h00, v, e);
        chk("halt after skip", 32'h2, v & 32'h2);
        wr(`ACCT_IDX_PIN, 8'h01);
        wr(`ACCT_IDX_LP, 8'h03);
        wr(`ACCT_IDX_CFG, 8'h02);
        wsig(0, 1'b1, 1200, n);
        repeat (40) @(posedge clk_i);
        chk("sleep held", 32'h1, {31'h0, |core_sleep});
        wr(`ACCT_IDX_SOFT, 8'h00);
        repeat (10) @(posedge clk_i);
        chk("soft bit ignored", 32'h1, {31'h0, |core_sleep});
        trig_low <= 1'b1;
        wsig(0, 1'b0, 20, n);
        trig_low <= 1'b0;
        wr(`ACCT_IDX_SOFT, 8'h01);
        wr(`ACCT_IDX_PIN, 8'h00);
        wsig(0, 1'b1, 1200, n);
        trig_low <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("pin ignored", 32'h1, {31'h0, |core_sleep});
        wr(`ACCT_IDX_SOFT, 8'h00);
        wsig(0, 1'b0, 20, n);
        trig_low <= 1'b0;
        wr(`ACCT_IDX_SOFT, 8'h01);
        wr(`ACCT_IDX_LP, 8'h01);
        wsig(0, 1'b1, 1200, n);
        wsig(0, 1'b0, 40, n);
        chk("sleep length", 32'h1, {31'h0, n >= 8 && n <= 16});
        wsig(1, 1'b1, 40, n);
        chk("settle length", 32'h1, {31'h0, n >= 8 && n <= 16});
        wr(`ACCT_IDX_CFG, 8'h06);
        for (n = 0; n < 400; n++)
        begin
            apb(1'b0, `ACCT_IDX_STAT, 8'h00, v, e);
            if (v[1] === 1'b1)
                break;
        end
        chk("halt reached", 32'h1, {31'h0, n < 400});
        chk("halt stops cal", 32'h0, {30'h0, core_cal});
        wr(`ACCT_IDX_CFG, 8'h02);
        repeat (5) @(posedge clk_i);
        apb(1'b0, `ACCT_IDX_STAT, 8'h00, v, e);
        chk("halt cleared", 32'h0, v & 32'h2);
        wrap_up();
    end
endmodule
